// [verilog/pvcr_regs.sv]
// apb register block of the port virtual channel extended capability.
// assumes apb with one wait state, pclk at 40 mhz, the arbitration table
// itself living in a neighbouring block that pulses table_entry_written.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "pvcr_params.svh"

// Contract
// - header low half reads 0002h
// - header version field reads 1h
// - next capability pointer reads 20Ch
// - extra channel count reads zero
// - low priority count, reset zero, strap loadable
// - reference clock encoding fixed 00b
// - table entry size reads 10b
// - group arbitration capability reads zero
// - arbitration table offset reads 00h
// - load bit applies table, reads zero
// - scheme select accepts 0, 1 only
// - table write sets status bit 16
// - status clears when table load finishes
module pvcr_regs #(
	parameter int       LOAD_CYCLES = `PVCR_LOAD_CYCLES,
	parameter bit [7:0] ARB_CAP     = `PVCR_ARB_CAP_RESET
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// arbitration table side
	input  wire logic        table_entry_written,
	output logic             table_apply_strobe,
	output logic             table_load_busy,
	output logic             table_status,
	output logic      [2:0]  arb_select,
	// default override from the serial loader
	input  wire logic        group_override_valid,
	input  wire logic [2:0]  group_override_value,
	output logic      [2:0]  low_priority_channel_group
);

	// address decode, used for both read and write paths
	function automatic pvcr_pkg::pvcr_reg_t decode(input logic [11:0] addr);
		unique case (addr)
			`PVCR_OFS_HEADER:      decode = pvcr_pkg::PVCR_REG_HEADER;
			`PVCR_OFS_CAP_ONE:     decode = pvcr_pkg::PVCR_REG_CAP_ONE;
			`PVCR_OFS_CAP_TWO:     decode = pvcr_pkg::PVCR_REG_CAP_TWO;
			`PVCR_OFS_CTRL_STATUS: decode = pvcr_pkg::PVCR_REG_CTRL_STATUS;
			default:               decode = pvcr_pkg::PVCR_REG_NONE;
		endcase
	endfunction

	// only the two defined schemes pass; anything else falls to default
	function automatic logic [2:0] legal_sel(input logic [2:0] raw);
		if (raw == pvcr_pkg::PVCR_ARB_WRR) begin
			legal_sel = pvcr_pkg::PVCR_ARB_WRR;
		end else begin
			legal_sel = pvcr_pkg::PVCR_ARB_FIXED;
		end
	endfunction

	pvcr_pkg::pvcr_reg_t sel_reg;
	logic                access_go;
	logic                commit;
	logic                wr_ctrl;
	logic                load_cmd;
	logic                load_done;
	logic                load_busy;
	logic                apply_strobe;
	logic [2:0]          sel_q;
	logic [2:0]          group_cnt_q;
	logic                tbl_status_q;
	logic                pready_q;
	logic                pslverr_q;
	logic [31:0]         prdata_q;
	logic [31:0]         rd_word;

	assign sel_reg   = decode(paddr);
	// first access cycle: answer is prepared here
	assign access_go = psel && penable && !pready_q;
	// edge at which the master samples pready high
	assign commit    = psel && penable && pready_q;
	assign wr_ctrl   = commit && pwrite && pstrb[0]
	                   && (sel_reg == pvcr_pkg::PVCR_REG_CTRL_STATUS);
	assign load_cmd  = wr_ctrl && pwdata[`PVCR_CTRL_LOAD_BIT];

	// read word assembly; reserved bits stay zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (sel_reg)
			pvcr_pkg::PVCR_REG_HEADER: begin
				rd_word[15:0]  = `PVCR_EXT_CAP_ID;
				rd_word[19:16] = `PVCR_CAP_VERSION;
				rd_word[31:20] = `PVCR_NEXT_CAP_PTR;
			end
			pvcr_pkg::PVCR_REG_CAP_ONE: begin
				rd_word[2:0] = `PVCR_EXT_VC_COUNT;
				rd_word[`PVCR_CAP1_GROUP_LSB +: 3] = group_cnt_q;
				rd_word[`PVCR_CAP1_REFCLK_LSB +: 2] = `PVCR_REF_CLOCK_ENC;
				rd_word[`PVCR_CAP1_ESIZE_LSB +: 2] = `PVCR_ENTRY_SIZE_ENC;
			end
			pvcr_pkg::PVCR_REG_CAP_TWO: begin
				// capability only means something with a nonzero group count
				rd_word[7:0] = ARB_CAP;
				rd_word[`PVCR_CAP2_TBL_LSB +: 8] = `PVCR_ARB_TBL_OFS;
			end
			pvcr_pkg::PVCR_REG_CTRL_STATUS: begin
				// load bit is never stored, so it reads zero
				rd_word[`PVCR_CTRL_LOAD_BIT] = 1'b0;
				rd_word[`PVCR_CTRL_SEL_LSB +: 3] = sel_q;
				rd_word[`PVCR_STAT_TBL_BIT] = tbl_status_q;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// apb handshake: one wait state, pready high for one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= access_go;
			pslverr_q <= access_go && (sel_reg == pvcr_pkg::PVCR_REG_NONE);
		end
	end

	// read data captured with pready so it is steady when sampled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (access_go) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
		end else if (commit) begin
			prdata_q <= 32'h0000_0000;
		end
	end

	// scheme select; only lane 0 writes reach it, everything else is read-only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= `PVCR_SEL_RESET;
		end else if (wr_ctrl) begin
			sel_q <= legal_sel(pwdata[`PVCR_CTRL_SEL_LSB +: 3]);
		end
	end

	// group count default, replaceable by the serial loader only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_cnt_q <= `PVCR_GROUP_RESET;
		end else if (group_override_valid) begin
			group_cnt_q <= group_override_value;
		end
	end

	// table status: a table write in the finishing cycle keeps it set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbl_status_q <= 1'b0;
		end else if (table_entry_written) begin
			tbl_status_q <= 1'b1;
		end else if (load_done) begin
			tbl_status_q <= 1'b0;
		end
	end

	// the loader runs the table into the arbiter
	pvcr_table_loader #(
		.LOAD_CYCLES (LOAD_CYCLES)
	) u_loader (
		.pclk           (pclk),
		.presetn        (presetn),
		.start          (load_cmd),
		.apply_strobe_q (apply_strobe),
		.busy_q         (load_busy),
		.done_q         (load_done)
	);

	// outputs; copies of registers keep every port on a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			table_status               <= 1'b0;
			arb_select                 <= `PVCR_SEL_RESET;
			low_priority_channel_group <= `PVCR_GROUP_RESET;
		end else begin
			table_status               <= tbl_status_q;
			arb_select                 <= sel_q;
			low_priority_channel_group <= group_cnt_q;
		end
	end

	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign table_apply_strobe = apply_strobe;
	assign table_load_busy    = load_busy;

endmodule

// [verilog/pvcr_params.svh]
// offsets, field positions, reset values and timing counts of the
// port virtual channel capability register block.
// assumes byte addressing on a 12-bit configuration offset.
`ifndef PVCR_PARAMS_SVH
`define PVCR_PARAMS_SVH

// register byte offsets
`define PVCR_OFS_HEADER        12'h140
`define PVCR_OFS_CAP_ONE       12'h144
`define PVCR_OFS_CAP_TWO       12'h148
`define PVCR_OFS_CTRL_STATUS   12'h14C

// capability header fields
`define PVCR_EXT_CAP_ID        16'h0002
`define PVCR_CAP_VERSION       4'h1
`define PVCR_NEXT_CAP_PTR      12'h20C

// port vc capability one fields
`define PVCR_EXT_VC_COUNT      3'h0
`define PVCR_GROUP_RESET       3'h0
`define PVCR_REF_CLOCK_ENC     2'h0
`define PVCR_ENTRY_SIZE_ENC    2'h2
`define PVCR_CAP1_GROUP_LSB    4
`define PVCR_CAP1_REFCLK_LSB   8
`define PVCR_CAP1_ESIZE_LSB    10

// port vc capability two fields
`define PVCR_ARB_CAP_RESET     8'h00
`define PVCR_ARB_TBL_OFS       8'h00
`define PVCR_CAP2_TBL_LSB      24

// control and status fields
`define PVCR_CTRL_LOAD_BIT     0
`define PVCR_CTRL_SEL_LSB      1
`define PVCR_STAT_TBL_BIT      16
`define PVCR_SEL_RESET         3'h0

// table load duration in pclk cycles
`define PVCR_LOAD_CYCLES       8

`endif

// [verilog/pvcr_pkg.sv]
// types shared by the port virtual channel capability register block.
// assumes nothing beyond the parameter header.
package pvcr_pkg;

	// virtual channel arbitration schemes that are accepted
	typedef enum logic [2:0] {
		PVCR_ARB_FIXED = 3'h0,
		PVCR_ARB_WRR   = 3'h1
	} pvcr_arb_sel_t;

	// table loader sequence
	typedef enum logic [1:0] {
		PVCR_LD_IDLE,
		PVCR_LD_BUSY,
		PVCR_LD_DONE
	} pvcr_ld_state_t;

	// register selected by an address
	typedef enum logic [2:0] {
		PVCR_REG_HEADER,
		PVCR_REG_CAP_ONE,
		PVCR_REG_CAP_TWO,
		PVCR_REG_CTRL_STATUS,
		PVCR_REG_NONE
	} pvcr_reg_t;

endpackage

// [verilog/pvcr_table_loader.sv]
// loader that applies the stored vc arbitration table to the arbiter.
// assumes start is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ps
`include "pvcr_params.svh"

module pvcr_table_loader #(
	parameter int LOAD_CYCLES = `PVCR_LOAD_CYCLES
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// command
	input  wire logic start,
	// results
	output logic      apply_strobe_q,
	output logic      busy_q,
	output logic      done_q
);

	localparam int CW = $clog2(LOAD_CYCLES + 1);

	pvcr_pkg::pvcr_ld_state_t state_q;
	logic [CW-1:0]            count_q;

	// sequence: a start while busy is dropped, the load in flight covers it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= pvcr_pkg::PVCR_LD_IDLE;
			count_q <= '0;
		end else begin
			unique case (state_q)
				pvcr_pkg::PVCR_LD_IDLE: begin
					if (start) begin
						state_q <= pvcr_pkg::PVCR_LD_BUSY;
						count_q <= CW'(LOAD_CYCLES - 1);
					end
				end
				pvcr_pkg::PVCR_LD_BUSY: begin
					if (count_q == '0) begin
						state_q <= pvcr_pkg::PVCR_LD_DONE;
					end else begin
						count_q <= count_q - 1'b1;
					end
				end
				pvcr_pkg::PVCR_LD_DONE: begin
					state_q <= pvcr_pkg::PVCR_LD_IDLE;
				end
				default: begin
					state_q <= pvcr_pkg::PVCR_LD_IDLE;
				end
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apply_strobe_q <= 1'b0;
			busy_q         <= 1'b0;
			done_q         <= 1'b0;
		end else begin
			apply_strobe_q <= (state_q == pvcr_pkg::PVCR_LD_IDLE) && start;
			busy_q         <= (state_q == pvcr_pkg::PVCR_LD_IDLE) ? start
			                  : (state_q == pvcr_pkg::PVCR_LD_BUSY) && (count_q != '0);
			done_q         <= (state_q == pvcr_pkg::PVCR_LD_BUSY) && (count_q == '0);
		end
	end

endmodule

// [bench/pvcr_regs_props.sv]
// checker for the port vc capability register block.
// assumes it is bound into pvcr_regs and sees only its ports.
`timescale 1ns/1ps
`include "pvcr_params.svh"

module pvcr_regs_chk #(
	parameter int       LOAD_CYCLES = 8,
	parameter bit [7:0] ARB_CAP     = 8'h00
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// table side and override
	input wire logic        table_entry_written,
	input wire logic        table_apply_strobe,
	input wire logic        table_load_busy,
	input wire logic        table_status,
	input wire logic [2:0]  arb_select,
	input wire logic        group_override_valid,
	input wire logic [2:0]  group_override_value,
	input wire logic [2:0]  low_priority_channel_group
);
	// completed transfers of each kind
	wire       done_x  = psel && penable && pready;
	wire       rd_done = done_x && !pwrite;
	wire       wr_ctrl = done_x && pwrite && paddr == 12'h14C && pstrb[0];
	wire [2:0] sel_exp = (pwdata[3:1] == 3'h1) ? 3'h1 : 3'h0;
	wire       mapped  = paddr inside {12'h140, 12'h144, 12'h148, 12'h14C};
	logic [7:0] busy_cnt_q;

	// busy run length, cleared when idle so a stuck busy shows up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_cnt_q <= 8'h00;
		else
			busy_cnt_q <= table_load_busy ? busy_cnt_q + 8'h01 : 8'h00;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_hdr; rd_done && paddr == 12'h140 |-> prdata == 32'h20C10002; endproperty
	a_hdr: assert property (p_hdr) else $error("header word wrong");
	property p_cap1; rd_done && paddr == 12'h144 |-> (prdata & 32'hFFFFFF8F) == 32'h00000800
		&& prdata[6:4] == low_priority_channel_group; endproperty
	a_cap1: assert property (p_cap1) else $error("cap one wrong");
	property p_cap2; rd_done && paddr == 12'h148 |-> prdata == {8'h00, 16'h0000, ARB_CAP};
	endproperty
	a_cap2: assert property (p_cap2) else $error("cap two wrong");
	property p_ctrl; rd_done && paddr == 12'h14C |-> prdata[0] == 1'b0 && prdata[15:4] == 12'h000
		&& prdata[31:17] == 15'h0000 && prdata[3:1] == arb_select; endproperty
	a_ctrl: assert property (p_ctrl) else $error("control read wrong");
	property p_sel; wr_ctrl |-> ##2 arb_select == $past(sel_exp, 2); endproperty
	a_sel: assert property (p_sel) else $error("scheme select wrong");
	property p_load; wr_ctrl && pwdata[0] && !table_load_busy |-> ##[1:2] table_apply_strobe;
	endproperty
	a_load: assert property (p_load) else $error("load not started");
	property p_busy; $fell(table_load_busy) |-> busy_cnt_q == LOAD_CYCLES; endproperty
	a_busy: assert property (p_busy) else $error("load length wrong");
	property p_set; table_entry_written |-> ##[1:2] table_status; endproperty
	a_set: assert property (p_set) else $error("status not set");
	property p_clr; $fell(table_load_busy) && !table_entry_written |-> ##[0:3] !table_status;
	endproperty
	a_clr: assert property (p_clr) else $error("status not cleared");
	property p_bad; done_x && !mapped |-> pslverr && prdata == 32'h0; endproperty
	a_bad: assert property (p_bad) else $error("unmapped access wrong");
endmodule

bind pvcr_regs pvcr_regs_chk #(.LOAD_CYCLES(LOAD_CYCLES), .ARB_CAP(ARB_CAP)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .table_entry_written(table_entry_written),
	.table_apply_strobe(table_apply_strobe), .table_load_busy(table_load_busy),
	.table_status(table_status), .arb_select(arb_select),
	.group_override_valid(group_override_valid), .group_override_value(group_override_value),
	.low_priority_channel_group(low_priority_channel_group));

// [bench/tb_top.sv]
// self-checking bench for the port vc capability register block.
// assumes pvcr_regs with its apb slave on a 40 mhz pclk.
`timescale 1ns/1ps

module tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        table_entry_written = 0, group_override_valid = 0, pready, pslverr, er;
	logic        table_apply_strobe, table_load_busy, table_status;
	logic [2:0]  group_override_value = 3'h0, arb_select, low_priority_channel_group;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hF;
	int          errors = 0, compares = 0;

	pvcr_regs #(.LOAD_CYCLES(8)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .table_entry_written(table_entry_written),
		.table_apply_strobe(table_apply_strobe), .table_load_busy(table_load_busy),
		.table_status(table_status), .arb_select(arb_select),
		.group_override_valid(group_override_valid), .group_override_value(group_override_value),
		.low_priority_channel_group(low_priority_channel_group));

	// 25 ns clock
	initial forever #12.5 pclk = ~pclk;

	// one apb transfer; pready and data are read at the rising edge, before the
	// slave's own updates of that edge land, and the request is released there
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t no pready %h exp %h", $time, pready, 1'b1);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic t_ids();
		logic [11:0] a [3] = '{12'h140, 12'h144, 12'h148};
		logic [31:0] e [3] = '{32'h20C10002, 32'h00000800, 32'h00000000};
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, a[i], 32'h0);
			chk(rd, e[i]);
			apb(1'b1, a[i], 32'hFFFFFFFF);
			apb(1'b0, a[i], 32'h0);
			chk(rd, e[i]);
		end
		$display("test ids done");
	endtask

	task automatic t_group();
		@(posedge pclk) begin
			group_override_valid <= 1'b1;
			group_override_value <= 3'h5;
		end
		@(posedge pclk) group_override_valid <= 1'b0;
		apb(1'b0, 12'h144, 32'h0);
		chk(rd, 32'h00000850);
		chk({29'h0, low_priority_channel_group}, 32'h5);
		// a second reset must bring the strap value back to zero
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h144, 32'h0);
		chk(rd, 32'h00000800);
		$display("test override done");
	endtask

	task automatic t_sel();
		logic [2:0] x;
		for (int v = 0; v < 8; v++) begin
			x = (v == 1) ? 3'h1 : 3'h0;
			apb(1'b1, 12'h14C, {28'h0, v[2:0], 1'b0});
			apb(1'b0, 12'h14C, 32'h0);
			chk(rd, {28'h0, x, 1'b0});
			chk({29'h0, arb_select}, {29'h0, x});
		end
		// control byte lane off: the write must not land
		pstrb <= 4'hE;
		apb(1'b1, 12'h14C, 32'h2);
		pstrb <= 4'hF;
		apb(1'b0, 12'h14C, 32'h0);
		chk(rd, 32'h0);
		$display("test select done");
	endtask

	task automatic t_tbl();
		@(posedge pclk) table_entry_written <= 1'b1;
		@(posedge pclk) table_entry_written <= 1'b0;
		apb(1'b0, 12'h14C, 32'h0);
		chk(rd, 32'h00010000);
		chk({31'h0, table_status}, 32'h1);
		apb(1'b1, 12'h14C, 32'h1);
		repeat (3) @(negedge pclk);
		chk({31'h0, table_load_busy}, 32'h1);
		repeat (12) @(posedge pclk);
		apb(1'b0, 12'h14C, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, table_status}, 32'h0);
		$display("test table load done");
	endtask

	task automatic t_bad();
		apb(1'b1, 12'h150, 32'hFFFFFFFF);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h150, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test unmapped done");
	endtask

	task automatic summarize();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// main sequence after two cycles of reset
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_ids();
		t_group();
		t_sel();
		t_tbl();
		t_bad();
		summarize();
	end

	// the run needs under two hundred cycles; this cuts a hang short
	initial begin
		#100us;
		errors++;
		summarize();
	end
endmodule
